//--- swr_defs.svh
/*
  Constants of the single-wire front end: timing in ns, address map,
  command codes and reset values.
  Assumes a 50 ns system clock; included by bare name.
*/
`ifndef SWR_DEFS_SVH
`define SWR_DEFS_SVH

`define SWR_CLK_NS 50
`define SWR_CYC(ns) (((ns) + `SWR_CLK_NS - 1) / `SWR_CLK_NS)

// reset detection thresholds, standard and high speed
`define SWR_RST_STD_NS 480000
`define SWR_RST_OD_NS 48000
// presence answer: wait high, then hold low
`define SWR_PDH_STD_NS 15000
`define SWR_PDL_STD_NS 60000
`define SWR_PDH_OD_NS 2000
`define SWR_PDL_OD_NS 7000
// bit slot: sample point and read-zero hold
`define SWR_SLOT_STD_NS 30000
`define SWR_SLOT_OD_NS 4000

// linear address map
`define SWR_A_SRAM_HI 16'h01FF
`define SWR_A_REG_LO 16'h0200
`define SWR_A_REG_HI 16'h023F
`define SWR_A_XRAM_LO 16'h0240
`define SWR_A_XRAM_HI 16'h027F
`define SWR_A_LOG_LO 16'h1000
`define SWR_A_LOG_HI 16'h2FFF
`define SWR_A_LTMP_LO 16'h020C
`define SWR_A_LTMP_HI 16'h020F
`define SWR_A_STAT_LO 16'h0214
`define SWR_A_STAT_HI 16'h0215
`define SWR_A_RO_LO 16'h0219
`define SWR_A_RO_HI 16'h0226
`define SWR_A_CNT 16'h0223
`define SWR_A_PW_LO 16'h0227
`define SWR_A_PW_HI 16'h0236

// identity defaults are arbitrary values
`define SWR_ID_FAMILY 8'h5A
`define SWR_ID_SERIAL 48'h0000_1234_5678
`define SWR_CNT_FACTORY 24'h000010

// link-level command bytes
`define SWR_CMD_RDID 8'h33
`define SWR_CMD_MATCH 8'h55
`define SWR_CMD_SRCH 8'hF0
`define SWR_CMD_CSRCH 8'hEC
`define SWR_CMD_SKIP 8'hCC
`define SWR_CMD_ODSKIP 8'h3C
`define SWR_CMD_ODMATCH 8'h69
`define SWR_CMD_RESUME 8'hA5

`endif

//--- swr_pkg.sv
/*
  Types and the identity check function of the single-wire front end.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package swr_pkg;
  typedef enum logic [1:0] {L_IDLE, L_SLOT, L_PWAIT, L_PLOW} swr_link_e;
  typedef enum logic [2:0] {
    P_DEAD, P_ROM, P_TXID, P_MATCH, P_SRCH, P_FUNC
  } swr_proto_e;

  // R2: shift-and-xor generator for x^8+x^5+x^4+1, lsb of data first
  function automatic logic [7:0] swr_crc8(input logic [55:0] d);
    logic [7:0] c;
    logic fb;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      fb = c[0] ^ d[i];
      c = {1'b0, c[7:1]} ^ (fb ? 8'h8C : 8'h00);
    end
    return c;
  endfunction
endpackage
`default_nettype wire

//--- swr_fifo.sv
/*
  Small FIFO with registered read data, valid/ready on both sides.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module swr_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  if (D < 2 || (1 << AW) != D) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  logic [W-1:0] mem_q [D];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic ov_q, ov_d, push, load, empty;

  always_comb begin
    empty = wp_q == rp_q;
    in_ready = (wp_q - rp_q) != (AW+1)'(D);
    push = in_valid && in_ready;
    load = !empty && (!ov_q || out_ready);
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = load ? rp_q + 1'b1 : rp_q;
    ov_d = load ? 1'b1 : (out_ready ? 1'b0 : ov_q);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
      ov_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      ov_q <= ov_d;
    end
  end

  // storage carries no control state, so it needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
    if (load) begin
      out_data <= mem_q[rp_q[AW-1:0]];
    end
  end

  assign out_valid = ov_q;
endmodule
`default_nettype wire

//--- swr_front.sv
/*
  Slave front end of the single-wire link: reset/presence, bit slots,
  identity code, link-level commands, speed switch, function-phase byte
  stream into a FIFO, memory access gate and total-samples counter.
  Assumes an open-drain data line resolved outside and a 20 MHz clk.
*/
// Summary of operation
// R1: identity is family byte, 48-bit serial, then CRC of first 56 bits.
// R2: check value uses generator x^8+x^5+x^4+1 built from shifts and xors.
// R3: generator starts at zero, shifts family lsb first, then serial.
// R4: a receiver shifting all 64 bits through the generator gets zero.
// R5: master first sends one of eight link-level commands.
// R6: high-speed command byte at standard speed switches to high speed.
// R7: function commands are accepted only after a successful link command.
// R8: every byte travels least significant bit first.
// R9: scratchpad, 576 bytes SRAM, two register pages, 8192 log bytes.
// R10: all memory except identity and scratchpad shares one address space.
// R11: log memory, counters and some registers ignore master writes.
// R12: while a mission is programmed, both register pages refuse writes.
// R13: both password registers take writes but never read back.
// R14: link-level command logic runs from line power, rest from battery.
// R15: total-samples counter keeps a nonzero factory count, read-only.
// R16: master starts with a reset low pulse of the speed's length.
// R17: after reset, answer presence then wait for a link command byte.
// R18: a standard-length reset returns the link to standard speed.
`timescale 1ns/1ps
`default_nettype none
`include "swr_defs.svh"
module swr_front #(
  parameter int RST_STD_CYC = `SWR_CYC(`SWR_RST_STD_NS),
  parameter logic [7:0] FAMILY = `SWR_ID_FAMILY,
  parameter logic [47:0] SERIAL = `SWR_ID_SERIAL,
  parameter logic [23:0] CNT_FACTORY = `SWR_CNT_FACTORY,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic io_in,
  output logic io_out,
  output logic io_oe_b,
  output logic od_mode,
  output logic func_open,
  input wire logic mission_on,
  input wire logic alarm_on,
  input wire logic sample_pulse,
  input wire logic [15:0] mem_addr,
  input wire logic mem_wr,
  output logic mem_ok,
  output logic mem_hide,
  output logic [7:0] cnt_rdata,
  output logic [7:0] cmd_data,
  output logic cmd_valid,
  input wire logic cmd_ready
);
  import swr_pkg::*;

  // R1: identity layout
  // R3: check byte from zero seed
  localparam logic [63:0] ID = {swr_crc8({SERIAL, FAMILY}), SERIAL, FAMILY};
  localparam int RST_OD_CYC = `SWR_CYC(`SWR_RST_OD_NS);
  localparam logic [13:0] T_RSTS = 14'(RST_STD_CYC);
  localparam logic [13:0] T_RSTO = 14'(RST_OD_CYC);
  localparam logic [13:0] T_PDHS = 14'(`SWR_CYC(`SWR_PDH_STD_NS));
  localparam logic [13:0] T_PDLS = 14'(`SWR_CYC(`SWR_PDL_STD_NS));
  localparam logic [13:0] T_PDHO = 14'(`SWR_CYC(`SWR_PDH_OD_NS));
  localparam logic [13:0] T_PDLO = 14'(`SWR_CYC(`SWR_PDL_OD_NS));
  localparam logic [13:0] T_SLS = 14'(`SWR_CYC(`SWR_SLOT_STD_NS));
  localparam logic [13:0] T_SLO = 14'(`SWR_CYC(`SWR_SLOT_OD_NS));

  // a threshold inside our own presence pulse would read it as a reset
  if (RST_STD_CYC <= RST_OD_CYC || RST_STD_CYC > 16383 ||
    RST_STD_CYC <= `SWR_CYC(`SWR_PDL_STD_NS) + 1) begin : g_bad_rst
    $error("standard reset count out of range");
  end
  if (CNT_FACTORY == 24'h0) begin : g_bad_cnt
    $error("factory sample count must be nonzero");
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // pin synchroniser; sy1_q feeds sy2_q only
  logic sy1_q, sy2_q, ln_q, fall, rise;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sy1_q <= 1'b1;
      sy2_q <= 1'b1;
      ln_q <= 1'b1;
    end else begin
      sy1_q <= io_in;
      sy2_q <= sy1_q;
      ln_q <= sy2_q;
    end
  end
  assign fall = ln_q && !sy2_q;
  assign rise = !ln_q && sy2_q;

  // link timing group
  swr_link_e link_q, link_d;
  swr_proto_e pr_q, pr_d;
  logic [13:0] tm_q, tm_d, low_q, low_d;
  logic [13:0] t_pdh, t_pdl, t_slot;
  logic oe_b_q, oe_b_d, od_q, od_d, od_set;
  logic ev, rst_ev, tx_act, tx_bit;
  logic [5:0] ix_q, ix_d;
  logic [1:0] ph_q, ph_d;

  assign tx_act = pr_q == P_TXID || (pr_q == P_SRCH && ph_q != 2'h2);
  assign tx_bit = ID[ix_q] ^ (pr_q == P_SRCH && ph_q == 2'h1);

  always_comb begin
    link_d = link_q;
    tm_d = tm_q + 14'h1;
    oe_b_d = oe_b_q;
    od_d = od_q;
    ev = 1'b0;
    t_pdh = od_q ? T_PDHO : T_PDHS;
    t_pdl = od_q ? T_PDLO : T_PDLS;
    t_slot = od_q ? T_SLO : T_SLS;
    low_d = low_q;
    if (sy2_q) begin
      low_d = 14'h0;
    end else if (low_q != 14'h3FFF) begin
      low_d = low_q + 14'h1;
    end
    // R16: reset length judged at the rising edge
    rst_ev = rise && low_q >= (od_q ? T_RSTO : T_RSTS);
    if (rst_ev) begin
      link_d = L_PWAIT;
      tm_d = 14'h0;
      oe_b_d = 1'b1;
      // R18: standard-length reset drops high speed
      if (low_q >= T_RSTS) begin
        od_d = 1'b0;
      end
    end else begin
      case (link_q)
        L_IDLE: begin
          if (fall) begin
            link_d = L_SLOT;
            tm_d = 14'h0;
            oe_b_d = !(tx_act && !tx_bit);
          end
        end
        L_SLOT: begin
          if (tm_q == t_slot) begin
            link_d = L_IDLE;
            oe_b_d = 1'b1;
            ev = 1'b1;
          end
        end
        // R17: presence answer after reset
        L_PWAIT: begin
          if (tm_q == t_pdh) begin
            link_d = L_PLOW;
            tm_d = 14'h0;
            oe_b_d = 1'b0;
          end
        end
        L_PLOW: begin
          if (tm_q == t_pdl) begin
            link_d = L_IDLE;
            oe_b_d = 1'b1;
          end
        end
        default: link_d = L_IDLE;
      endcase
      // R6: switch speed once the command byte is complete
      if (od_set) begin
        od_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link_q <= L_IDLE;
      tm_q <= 14'h0;
      low_q <= 14'h0;
      oe_b_q <= 1'b1;
      od_q <= 1'b0;
    end else begin
      link_q <= link_d;
      tm_q <= tm_d;
      low_q <= low_d;
      oe_b_q <= oe_b_d;
      od_q <= od_d;
    end
  end

  // protocol group
  logic [7:0] sh_q, sh_d, pb_q, pb_d, byte_in;
  logic [2:0] bc_q, bc_d;
  logic rs_q, rs_d, pv_q, pv_d, fifo_rdy;

  // R14: this stage needs only line power, so keep it free of battery state
  always_comb begin
    pr_d = pr_q;
    sh_d = sh_q;
    bc_d = bc_q;
    ix_d = ix_q;
    ph_d = ph_q;
    rs_d = rs_q;
    pv_d = pv_q && !fifo_rdy;
    pb_d = pb_q;
    od_set = 1'b0;
    // R8: lsb first
    byte_in = {sy2_q, sh_q[7:1]};
    if (rst_ev) begin
      pr_d = P_ROM;
      bc_d = 3'h0;
    end else if (ev) begin
      case (pr_q)
        P_ROM: begin
          sh_d = byte_in;
          bc_d = bc_q + 3'h1;
          ix_d = 6'h0;
          ph_d = 2'h0;
          if (bc_q == 3'h7) begin
            rs_d = 1'b0;
            // R5: eight link-level commands
            case (byte_in)
              `SWR_CMD_RDID: pr_d = P_TXID;
              `SWR_CMD_MATCH: pr_d = P_MATCH;
              `SWR_CMD_SRCH: pr_d = P_SRCH;
              `SWR_CMD_CSRCH: pr_d = alarm_on ? P_SRCH : P_DEAD;
              `SWR_CMD_SKIP: pr_d = P_FUNC;
              `SWR_CMD_ODSKIP: begin
                pr_d = P_FUNC;
                od_set = !od_q;
              end
              `SWR_CMD_ODMATCH: begin
                pr_d = P_MATCH;
                od_set = !od_q;
              end
              `SWR_CMD_RESUME: begin
                pr_d = rs_q ? P_FUNC : P_DEAD;
                rs_d = rs_q;
              end
              default: pr_d = P_DEAD;
            endcase
          end
        end
        P_TXID: begin
          ix_d = ix_q + 6'h1;
          if (ix_q == 6'h3F) begin
            pr_d = P_FUNC;
          end
        end
        P_MATCH, P_SRCH: begin
          if (pr_q == P_SRCH && ph_q != 2'h2) begin
            ph_d = ph_q + 2'h1;
          end else if (sy2_q != ID[ix_q]) begin
            pr_d = P_DEAD;
          end else begin
            ph_d = 2'h0;
            ix_d = ix_q + 6'h1;
            // R7: function phase opens only after a full match
            if (ix_q == 6'h3F) begin
              pr_d = P_FUNC;
              rs_d = 1'b1;
            end
          end
        end
        // a full FIFO holds the byte and ignores slots until it drains
        P_FUNC: begin
          if (!pv_q) begin
            sh_d = byte_in;
            bc_d = bc_q + 3'h1;
            if (bc_q == 3'h7) begin
              pv_d = 1'b1;
              pb_d = byte_in;
            end
          end
        end
        default: pr_d = P_DEAD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pr_q <= P_DEAD;
      sh_q <= 8'h00;
      bc_q <= 3'h0;
      ix_q <= 6'h0;
      ph_q <= 2'h0;
      rs_q <= 1'b0;
      pv_q <= 1'b0;
      pb_q <= 8'h00;
    end else begin
      pr_q <= pr_d;
      sh_q <= sh_d;
      bc_q <= bc_d;
      ix_q <= ix_d;
      ph_q <= ph_d;
      rs_q <= rs_d;
      pv_q <= pv_d;
      pb_q <= pb_d;
    end
  end

  swr_fifo #(
    .W(8),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(pv_q),
    .in_ready(fifo_rdy),
    .in_data(pb_q),
    .out_valid(cmd_valid),
    .out_ready(cmd_ready),
    .out_data(cmd_data)
  );

  // access gate and samples counter
  logic in_sram, in_reg, in_log, ro, pw, ok_q, ok_d, hide_q, hide_d;
  logic [23:0] cnt_q, cnt_d;
  logic [7:0] crd_q, crd_d;
  logic [15:0] coff;

  always_comb begin
    // R9: SRAM pages and extension pages
    // R10: one linear map
    in_sram = mem_addr <= `SWR_A_SRAM_HI ||
      (mem_addr >= `SWR_A_XRAM_LO && mem_addr <= `SWR_A_XRAM_HI);
    in_reg = mem_addr >= `SWR_A_REG_LO && mem_addr <= `SWR_A_REG_HI;
    in_log = mem_addr >= `SWR_A_LOG_LO && mem_addr <= `SWR_A_LOG_HI;
    ro = in_log || (mem_addr >= `SWR_A_LTMP_LO &&
      mem_addr <= `SWR_A_LTMP_HI) || (mem_addr >= `SWR_A_STAT_LO &&
      mem_addr <= `SWR_A_STAT_HI) || (mem_addr >= `SWR_A_RO_LO &&
      mem_addr <= `SWR_A_RO_HI);
    pw = mem_addr >= `SWR_A_PW_LO && mem_addr <= `SWR_A_PW_HI;
    // R11: read-only areas
    // R12: register pages locked during a mission
    if (mem_wr) begin
      ok_d = in_sram || (in_reg && !ro && !mission_on);
    end else begin
      ok_d = in_sram || in_reg || in_log;
    end
    // R13: passwords read back as zero
    hide_d = !mem_wr && pw;
    // R15: saturates so it never returns to zero
    cnt_d = (sample_pulse && cnt_q != 24'hFFFFFF) ? cnt_q + 24'h1 : cnt_q;
    coff = mem_addr - `SWR_A_CNT;
    case (coff)
      16'h0000: crd_d = cnt_q[7:0];
      16'h0001: crd_d = cnt_q[15:8];
      16'h0002: crd_d = cnt_q[23:16];
      default: crd_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ok_q <= 1'b0;
      hide_q <= 1'b0;
      cnt_q <= CNT_FACTORY;
      crd_q <= 8'h00;
    end else begin
      ok_q <= ok_d;
      hide_q <= hide_d;
      cnt_q <= cnt_d;
      crd_q <= crd_d;
    end
  end

  assign io_out = 1'b0;
  assign io_oe_b = oe_b_q;
  assign od_mode = od_q;
  assign func_open = pr_q == P_FUNC;
  assign mem_ok = ok_q;
  assign mem_hide = hide_q;
  assign cnt_rdata = crd_q;

  a_presence_low: assert property ( // R17
    rst_ev |-> ##[1:400] !oe_b_q)
    else $error("no presence pulse after reset");
  a_rom_wait: assert property ( // R17
    rst_ev |=> pr_q == P_ROM)
    else $error("reset did not return to command wait");
  a_od_entry: assert property ( // R6
    ev && !rst_ev && pr_q == P_ROM && bc_q == 3'h7 &&
    byte_in == `SWR_CMD_ODSKIP |=> od_q && pr_q == P_FUNC)
    else $error("high-speed skip did not switch speed");
  a_od_exit: assert property ( // R18
    rst_ev && low_q >= T_RSTS |=> !od_q)
    else $error("long reset kept high speed");
  a_func_gate: assert property ( // R7
    $rose(pv_q) |-> $past(pr_q) == P_FUNC)
    else $error("function byte taken before command phase");
  a_lsb_first: assert property ( // R8
    ev && !rst_ev && pr_q == P_ROM |=> sh_q[7] == $past(sy2_q))
    else $error("bit not shifted in lsb first");
  a_match_drop: assert property ( // R1
    ev && !rst_ev && pr_q == P_MATCH && sy2_q != ID[ix_q]
    |=> pr_q == P_DEAD)
    else $error("mismatched identity bit kept device selected");
  a_mission_lock: assert property ( // R12
    mem_wr && mission_on && in_reg |=> !mem_ok)
    else $error("register page write allowed in mission");
  a_log_ro: assert property ( // R11
    mem_wr && in_log |=> !mem_ok)
    else $error("write to log memory allowed");
  a_pw_hidden: assert property ( // R13
    !mem_wr && pw |=> mem_hide)
    else $error("password read not hidden");
  a_cnt_kept: assert property ( // R15
    cnt_q != 24'h0)
    else $error("samples counter reached zero");
endmodule
`default_nettype wire

//--- swr_master_model.sv
/*
  Behavioural bus master on the single data line: reset pulse, bit slots,
  bytes. Assumes the caller sits just after a rising clk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module swr_master_model #(
  parameter int RST_CYC = 1220
) (
  input wire logic clk,
  input wire logic io_oe_b,
  input wire logic io_out,
  output logic line
);
  logic m_low;
  logic hs;
  initial begin
    m_low = 1'b0;
    hs = 1'b0;
  end
  // pull-up: the line is high unless either party pulls it low
  assign line = ~m_low & (io_oe_b | io_out);
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_speed(input logic fast);
    hs = fast;
  endtask
  // reset low time, shortened with the device threshold
  task automatic line_reset(output logic present);
    m_low = 1'b1;
    wait_cyc(hs ? 1000 : RST_CYC);
    m_low = 1'b0;
    wait_cyc(hs ? 100 : 700);
    present = ~line;
    wait_cyc(hs ? 150 : 900);
  endtask
  task automatic wbit(input logic b);
    m_low = 1'b1;
    wait_cyc(b ? 3 : (hs ? 100 : 640));
    m_low = 1'b0;
    wait_cyc(b ? (hs ? 112 : 657) : (hs ? 15 : 20));
  endtask
  task automatic rbit(output logic b);
    m_low = 1'b1;
    wait_cyc(2);
    m_low = 1'b0;
    wait_cyc(hs ? 40 : 300);
    b = line;
    wait_cyc(hs ? 75 : 380);
  endtask
  // command and data bytes go out lsb first
  task automatic wbyte(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      wbit(d[i]);
    end
  endtask
endmodule
`default_nettype wire

//--- tb_swr_front.sv
/*
  Self-checking bench of the single-wire front end: identity read, speed
  switch, command FIFO and access gate. Assumes swr_master_model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_swr_front;
  localparam int RST_CYC = 1400;
  // identity values are arbitrary
  localparam logic [7:0] FAM = 8'h3E;
  localparam logic [47:0] SER = 48'hC0FF_EE12_3456;
  localparam logic [23:0] CNT_INIT = 24'h0A0B0C;
  logic clk, rst_b, io_line, io_oe_b, od_mode, func_open;
  logic mission_on, alarm_on, sample_pulse, mem_wr, mem_ok, mem_hide;
  logic cmd_valid, cmd_ready, pres, b, io_drv;
  logic [15:0] mem_addr;
  logic [7:0] cnt_rdata, cmd_data;
  logic [63:0] id;
  int mismatches, n_tests, cyc;

  swr_front #(.RST_STD_CYC(RST_CYC), .FAMILY(FAM), .SERIAL(SER),
    .CNT_FACTORY(CNT_INIT)) dut (
    .clk(clk), .rst_b(rst_b), .io_in(io_line), .io_out(io_drv),
    .io_oe_b(io_oe_b), .od_mode(od_mode), .func_open(func_open),
    .mission_on(mission_on), .alarm_on(alarm_on),
    .sample_pulse(sample_pulse), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_ok(mem_ok), .mem_hide(mem_hide), .cnt_rdata(cnt_rdata),
    .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready));
  swr_master_model #(.RST_CYC(RST_CYC + 20)) u_mst (
    .clk(clk), .io_oe_b(io_oe_b), .io_out(io_drv), .line(io_line));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // reflected form of x^8+x^5+x^4+1, fed lsb first from zero
  function automatic logic [7:0] crc_of(input logic [63:0] v, input int n);
    logic [7:0] c = 8'h00;
    for (int i = 0; i < n; i++) begin
      c = (c[0] ^ v[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    end
    return c;
  endfunction

  function automatic logic [7:0] pat(input int k);
    return 8'(k * 37 + 129);
  endfunction

  task automatic acc(input logic [15:0] a, input logic w, input logic m,
                     input logic ok, input logic hide);
    mem_addr = a;
    mem_wr = w;
    mission_on = m;
    @(posedge clk);
    #1;
    check(mem_ok, ok);
    check(mem_hide, hide);
  endtask

  task automatic wait_valid();
    int t = 0;
    while (cmd_valid !== 1'b1 && t < 100) begin
      @(posedge clk);
      #1;
      t++;
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    rst_b = 1'b0;
    mission_on = 1'b0;
    alarm_on = 1'b0;
    sample_pulse = 1'b0;
    mem_addr = 16'h0000;
    mem_wr = 1'b0;
    cmd_ready = 1'b0;
    mismatches = 0;
    n_tests = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    #1;
    rst_b = 1'b1;
    u_mst.wait_cyc(4);
    check(func_open, 1'b0);
    check(od_mode, 1'b0);
    acc(16'h0000, 1'b0, 1'b0, 1'b1, 1'b0);
    acc(16'h01FF, 1'b1, 1'b0, 1'b1, 1'b0);
    acc(16'h0240, 1'b1, 1'b0, 1'b1, 1'b0);
    acc(16'h0200, 1'b1, 1'b0, 1'b1, 1'b0);
    acc(16'h0200, 1'b1, 1'b1, 1'b0, 1'b0);
    acc(16'h0210, 1'b0, 1'b1, 1'b1, 1'b0);
    acc(16'h020C, 1'b1, 1'b0, 1'b0, 1'b0);
    acc(16'h0214, 1'b1, 1'b0, 1'b0, 1'b0);
    acc(16'h1000, 1'b1, 1'b0, 1'b0, 1'b0);
    acc(16'h2FFF, 1'b0, 1'b0, 1'b1, 1'b0);
    acc(16'h3000, 1'b0, 1'b0, 1'b0, 1'b0);
    acc(16'h0227, 1'b1, 1'b0, 1'b1, 1'b0);
    acc(16'h0236, 1'b0, 1'b0, 1'b1, 1'b1);
    acc(16'h0223, 1'b1, 1'b0, 1'b0, 1'b0);
    acc(16'h0223, 1'b0, 1'b0, 1'b1, 1'b0);
    check(cnt_rdata, CNT_INIT[7:0]);
    acc(16'h0225, 1'b0, 1'b0, 1'b1, 1'b0);
    check(cnt_rdata, CNT_INIT[23:16]);
    sample_pulse = 1'b1;
    u_mst.wait_cyc(1);
    sample_pulse = 1'b0;
    acc(16'h0223, 1'b0, 1'b0, 1'b1, 1'b0);
    check(cnt_rdata, CNT_INIT[7:0] + 8'h01);
    acc(16'h0224, 1'b0, 1'b0, 1'b1, 1'b0);
    check(cnt_rdata, CNT_INIT[15:8]);
    // identity read at standard speed
    u_mst.line_reset(pres);
    check(pres, 1'b1);
    u_mst.wbyte(8'h33);
    for (int i = 0; i < 64; i++) begin
      u_mst.rbit(b);
      id[i] = b;
    end
    check(id[7:0], FAM);
    check(id[55:8], SER);
    check(id[63:56], crc_of({8'h00, SER, FAM}, 56));
    check(crc_of(id, 64), 8'h00);
    check(func_open, 1'b1);
    check(od_mode, 1'b0);
    // high-speed skip, then fill the command FIFO with the consumer stalled
    u_mst.line_reset(pres);
    check(pres, 1'b1);
    u_mst.wbyte(8'h3C);
    check(od_mode, 1'b1);
    check(func_open, 1'b1);
    u_mst.set_speed(1'b1);
    for (int k = 0; k < 11; k++) begin
      u_mst.wbyte(pat(k));
    end
    check(cmd_valid, 1'b1);
    // eleventh byte arrived while the tenth waited, so it is lost
    for (int k = 0; k < 10; k++) begin
      wait_valid();
      check(cmd_data, pat(k));
      cmd_ready = 1'b1;
      u_mst.wait_cyc(1);
      cmd_ready = 1'b0;
    end
    u_mst.wait_cyc(5);
    check(cmd_valid, 1'b0);
    // conditional search at high speed with an alarm pending
    alarm_on = 1'b1;
    u_mst.line_reset(pres);
    check(pres, 1'b1);
    u_mst.wbyte(8'hEC);
    u_mst.rbit(b);
    check(b, FAM[0]);
    u_mst.rbit(b);
    check(b, !FAM[0]);
    u_mst.wbit(FAM[0]);
    check(func_open, 1'b0);
    // without an alarm the device drops out until the next reset
    alarm_on = 1'b0;
    u_mst.line_reset(pres);
    check(pres, 1'b1);
    check(od_mode, 1'b1);
    u_mst.wbyte(8'hEC);
    u_mst.rbit(b);
    check(b, 1'b1);
    check(func_open, 1'b0);
    // standard-length reset drops back to standard speed
    u_mst.set_speed(1'b0);
    u_mst.line_reset(pres);
    check(pres, 1'b1);
    check(od_mode, 1'b0);
    u_mst.wbyte(8'h00);
    check(func_open, 1'b0);
    u_mst.wbyte(8'h5A);
    u_mst.wait_cyc(5);
    check(cmd_valid, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
